// ### core/sbm_pkg.sv
package sbm_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int BANK_W   = 2;
   localparam int ROW_W    = 13;
   localparam int COL_W    = 10;
   localparam int NBANK    = 4;
   localparam int CNT_W    = 13;

   // ----------------------------------------------------------------
   // clocking: half rate, two memory clocks per local clock
   // ----------------------------------------------------------------
   localparam int RATE          = 2;
   localparam int MEM_MHZ       = 1200;
   localparam int CMD_LATENCY   = 9;

   // ----------------------------------------------------------------
   // timing, printed figures and derived local-clock counts
   // ----------------------------------------------------------------
   localparam int TRP_NS        = 15;
   localparam int TRP_MEM_CYC   = 18;
   localparam int TRFC_NS       = 260;
   localparam int TRFC_MEM_CYC  = 313;
   localparam int TRCD_NS       = 15;
   localparam int TRCD_MEM_CYC  = (TRCD_NS * MEM_MHZ + 999) / 1000;
   localparam int TREFI_NS      = 7800;
   localparam int TRP_LC        = (TRP_MEM_CYC + RATE - 1) / RATE;
   localparam int TRFC_LC       = (TRFC_MEM_CYC + RATE - 1) / RATE;
   localparam int TRCD_LC       = (TRCD_MEM_CYC + RATE - 1) / RATE;
   localparam int TREFI_LC      = (TREFI_NS * MEM_MHZ) / (1000 * RATE);

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SBM_NOP,
      SBM_ACT,
      SBM_PRE,
      SBM_RD,
      SBM_WR,
      SBM_REF
   } sbm_cmd_e_t;

   typedef struct packed {
      logic              write;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
   } sbm_req_t;

   typedef struct packed {
      logic              valid;
      sbm_cmd_e_t        cmd;
      logic              all_banks;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
   } sbm_cmd_t;

endpackage

// ### core/sbm_cmd_delay.sv
`timescale 1ns/1ns
`default_nettype none

module sbm_cmd_delay
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  var  sbm_pkg::sbm_cmd_t cmd_i,
   output var  sbm_pkg::sbm_cmd_t cmd_o
);

   sbm_pkg::sbm_cmd_t stage_q [sbm_pkg::CMD_LATENCY];

   // ----------------------------------------------------------------
   // fixed-latency command pipe
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < sbm_pkg::CMD_LATENCY; g++)
      begin : g_stage
         always_ff @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
               stage_q[g] <= '0;
            else if (g == 0)
               stage_q[g] <= cmd_i;
            else
               stage_q[g] <= stage_q[(g == 0) ? 0 : g - 1];
         end
      end
   endgenerate

   assign cmd_o = stage_q[sbm_pkg::CMD_LATENCY-1];

endmodule // sbm_cmd_delay

`default_nettype wire

// ### core/sbm_bank_ctrl.sv
// Behaviour
// - a bank must hold an activated row before any read or write to it.
// - after activate, wait the row-to-column delay before read or write.
// - a row miss precharges the bank first, then activates the new row.
// - precharge closes one selected bank or all banks together.
// - refresh is precharge all (only if a row is open) then auto-refresh wait; user traffic is held off.
// - precharge-to-next-command wait is 18 memory clocks.
// - refresh recovery wait is 313 memory clocks before the next command.
// - back-to-back hits to an open row issue one command per cycle.
// - commands reach memory 9 local cycles after the request is taken.
// - one local cycle spans two memory clocks; wait counts are halved, rounded up, the refresh interval rounded down.
`timescale 1ns/1ns
`default_nettype none

module sbm_bank_ctrl
#(
   parameter int REFI_CYCLES = sbm_pkg::TREFI_LC
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              req_valid_i,
   input  var  sbm_pkg::sbm_req_t req_i,
   output logic                   req_ready_o,
   output logic                   refresh_busy_o,
   output var  sbm_pkg::sbm_cmd_t mem_cmd_o
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PRE,
      ST_ACT,
      ST_WAIT,
      ST_REF_PRE,
      ST_REF
   } sbm_state_t;

   localparam logic [sbm_pkg::CNT_W-1:0] TRP_C  = sbm_pkg::CNT_W'(sbm_pkg::TRP_LC);
   localparam logic [sbm_pkg::CNT_W-1:0] TRCD_C = sbm_pkg::CNT_W'(sbm_pkg::TRCD_LC);
   localparam logic [sbm_pkg::CNT_W-1:0] TRFC_C = sbm_pkg::CNT_W'(sbm_pkg::TRFC_LC);
   localparam logic [sbm_pkg::CNT_W-1:0] REFI_C = sbm_pkg::CNT_W'(REFI_CYCLES);
   localparam logic [sbm_pkg::CNT_W-1:0] ONE_C  = sbm_pkg::CNT_W'(1);

   sbm_state_t                         state_q;
   sbm_state_t                         state_d;
   sbm_state_t                         after_q;
   sbm_state_t                         after_d;
   logic [sbm_pkg::CNT_W-1:0]          wait_q;
   logic [sbm_pkg::CNT_W-1:0]          wait_d;
   logic [sbm_pkg::CNT_W-1:0]          refi_q;
   logic                               ref_pend_q;
   logic [sbm_pkg::NBANK-1:0]          open_q;
   logic [sbm_pkg::ROW_W-1:0]          row_q [sbm_pkg::NBANK];
   logic                               hit;
   logic                               any_open;
   logic                               req_fire;
   sbm_pkg::sbm_cmd_t                  cmd;

   // ----------------------------------------------------------------
   // scheduling decision
   // ----------------------------------------------------------------
   assign hit      = open_q[req_i.bank] && (row_q[req_i.bank] == req_i.row);
   assign any_open = |open_q;
   // refresh has priority so a stream of hits cannot starve it
   assign req_ready_o    = (state_q == ST_IDLE) && !ref_pend_q && hit;
   assign req_fire       = req_valid_i && req_ready_o;
   assign refresh_busy_o = ref_pend_q;

   always_comb
   begin
      state_d = state_q;
      after_d = after_q;
      wait_d  = wait_q;
      cmd     = '0;
      cmd.cmd = sbm_pkg::SBM_NOP;
      case (state_q)
         ST_IDLE:
         begin
            if (ref_pend_q)
               state_d = any_open ? ST_REF_PRE : ST_REF;
            else if (req_fire)
            begin
               cmd.valid = 1'b1;
               cmd.cmd   = req_i.write ? sbm_pkg::SBM_WR : sbm_pkg::SBM_RD;
               cmd.bank  = req_i.bank;
               cmd.row   = req_i.row;
               cmd.col   = req_i.col;
            end
            else if (req_valid_i)
               state_d = open_q[req_i.bank] ? ST_PRE : ST_ACT;
         end
         ST_PRE:
         begin
            cmd.valid = 1'b1;
            cmd.cmd   = sbm_pkg::SBM_PRE;
            cmd.bank  = req_i.bank;
            wait_d    = TRP_C - ONE_C;
            after_d   = ST_ACT;
            state_d   = ST_WAIT;
         end
         ST_ACT:
         begin
            cmd.valid = 1'b1;
            cmd.cmd   = sbm_pkg::SBM_ACT;
            cmd.bank  = req_i.bank;
            cmd.row   = req_i.row;
            wait_d    = TRCD_C - ONE_C;
            after_d   = ST_IDLE;
            state_d   = ST_WAIT;
         end
         ST_REF_PRE:
         begin
            cmd.valid     = 1'b1;
            cmd.cmd       = sbm_pkg::SBM_PRE;
            cmd.all_banks = 1'b1;
            wait_d        = TRP_C - ONE_C;
            after_d       = ST_REF;
            state_d       = ST_WAIT;
         end
         ST_REF:
         begin
            cmd.valid = 1'b1;
            cmd.cmd   = sbm_pkg::SBM_REF;
            wait_d    = TRFC_C - ONE_C;
            after_d   = ST_IDLE;
            state_d   = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (wait_q == '0)
               state_d = after_q;
            else
               wait_d = wait_q - ONE_C;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
         after_q <= ST_IDLE;
         wait_q  <= '0;
      end
      else
      begin
         state_q <= state_d;
         after_q <= after_d;
         wait_q  <= wait_d;
      end
   end

   // ----------------------------------------------------------------
   // open-row bookkeeping
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         open_q <= '0;
         for (int b = 0; b < sbm_pkg::NBANK; b++)
            row_q[b] <= '0;
      end
      else if (cmd.cmd == sbm_pkg::SBM_ACT)
      begin
         open_q[cmd.bank] <= 1'b1;
         row_q[cmd.bank]  <= cmd.row;
      end
      else if (cmd.cmd == sbm_pkg::SBM_PRE)
      begin
         if (cmd.all_banks)
            open_q <= '0;
         else
            open_q[cmd.bank] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // refresh interval
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         refi_q     <= '0;
         ref_pend_q <= 1'b0;
      end
      else
      begin
         refi_q <= (refi_q >= REFI_C - ONE_C) ? '0 : refi_q + ONE_C;
         // a new interval expiring with the refresh issue still sets pending
         if (refi_q >= REFI_C - ONE_C)
            ref_pend_q <= 1'b1;
         else if (cmd.cmd == sbm_pkg::SBM_REF)
            ref_pend_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // command latency to memory; half-rate, one command per local cycle
   // ----------------------------------------------------------------
   sbm_cmd_delay u_delay
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cmd_i (cmd),
      .cmd_o (mem_cmd_o)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [sbm_pkg::CNT_W-1:0] since_act_q;
   logic [sbm_pkg::CNT_W-1:0] since_pre_q;
   logic [sbm_pkg::CNT_W-1:0] since_ref_q;
   logic                      rw;

   assign rw = (cmd.cmd == sbm_pkg::SBM_RD) || (cmd.cmd == sbm_pkg::SBM_WR);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         since_act_q <= '1;
         since_pre_q <= '1;
         since_ref_q <= '1;
      end
      else
      begin
         since_act_q <= (cmd.cmd == sbm_pkg::SBM_ACT) ? ONE_C :
                        (since_act_q == '1) ? since_act_q : since_act_q + ONE_C;
         since_pre_q <= (cmd.cmd == sbm_pkg::SBM_PRE) ? ONE_C :
                        (since_pre_q == '1) ? since_pre_q : since_pre_q + ONE_C;
         since_ref_q <= (cmd.cmd == sbm_pkg::SBM_REF) ? ONE_C :
                        (since_ref_q == '1) ? since_ref_q : since_ref_q + ONE_C;
      end
   end

   sequence s_accept;
      req_fire;
   endsequence

   sequence s_all_pre;
      cmd.cmd == sbm_pkg::SBM_PRE && cmd.all_banks;
   endsequence

   a_rw_open_row: assert property (@(posedge clk_i) disable iff (rst_i)
      rw |-> open_q[cmd.bank] && row_q[cmd.bank] == cmd.row)
      else $error("read or write to a closed row");

   a_trcd_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      rw |-> since_act_q >= TRCD_C)
      else $error("read or write before row-to-column delay");

   a_act_closed: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd.cmd == sbm_pkg::SBM_ACT |-> !open_q[cmd.bank])
      else $error("activate on a bank with an open row");

   a_pre_all_scope: assert property (@(posedge clk_i) disable iff (rst_i)
      s_all_pre |=> open_q == '0)
      else $error("precharge all left a bank open");

   a_ref_sequence: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd.cmd == sbm_pkg::SBM_REF |-> !any_open && !req_ready_o)
      else $error("refresh with open rows or traffic allowed");

   a_trp_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd.valid && cmd.cmd != sbm_pkg::SBM_PRE |-> since_pre_q >= TRP_C)
      else $error("command inside precharge wait");

   a_trfc_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd.valid && cmd.cmd != sbm_pkg::SBM_REF |-> since_ref_q >= TRFC_C)
      else $error("command inside refresh recovery");

   // two hits on consecutive cycles must leave the pipe as two adjacent commands
   a_hit_streams: assert property (@(posedge clk_i) disable iff (rst_i)
      s_accept ##1 s_accept |-> ##9 mem_cmd_o.valid && $past(mem_cmd_o.valid))
      else $error("back-to-back hit not issued each cycle");

   a_cmd_latency: assert property (@(posedge clk_i) disable iff (rst_i)
      s_accept |-> ##9 mem_cmd_o.valid && mem_cmd_o.col == $past(req_i.col, 9))
      else $error("command latency is not nine cycles");

   a_refresh_due: assert property (@(posedge clk_i) disable iff (rst_i)
      refi_q == REFI_C - ONE_C |=> ref_pend_q)
      else $error("refresh interval did not raise pending");

endmodule // sbm_bank_ctrl

`default_nettype wire

// ### tb/sbm_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// memory device: tracks banks and counts illegal commands
// ----------------------------------------------------------------
module sbm_mem_model
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  var  sbm_pkg::sbm_cmd_t cmd_i,
   output var  logic [7:0]        viol_o
);
   int                n, ref_at, lp, act_at [4], pre_at [4];
   logic              opn [4];
   logic [12:0]       row [4];
   logic [2:0]        k;
   sbm_pkg::sbm_cmd_t c;

   always @(posedge clk_i or posedge rst_i)
   begin
      c = cmd_i;
      k = c.cmd;
      n = n + 1;
      if (rst_i)
      begin
         ref_at = -999;
         lp     = -999;
         viol_o = 8'h00;
         foreach (opn[b])
         begin
            opn[b]    = 1'b0;
            act_at[b] = -999;
            pre_at[b] = -999;
         end
      end
      else if (c.valid)
      begin
         if (n - ref_at < sbm_pkg::TRFC_LC) viol_o++;
         if (k == 3'h1 && (opn[c.bank] || n - pre_at[c.bank] < sbm_pkg::TRP_LC)) viol_o++;
         if ((k == 3'h3 || k == 3'h4) && !opn[c.bank]) viol_o++;
         if ((k == 3'h3 || k == 3'h4) && row[c.bank] !== c.row) viol_o++;
         if ((k == 3'h3 || k == 3'h4) && n - act_at[c.bank] < sbm_pkg::TRCD_LC) viol_o++;
         if (k == 3'h5 && (opn.or() || n - lp < sbm_pkg::TRP_LC)) viol_o++;
         if (k == 3'h5) ref_at = n;
         if (k == 3'h1)
         begin
            opn[c.bank]    = 1'b1;
            row[c.bank]    = c.row;
            act_at[c.bank] = n;
         end
         foreach (opn[b])
         begin
            // one bank or every bank closes
            if (k == 3'h2 && (c.all_banks || b == int'(c.bank))) opn[b] = 1'b0;
            if (k == 3'h2 && (c.all_banks || b == int'(c.bank))) pre_at[b] = n;
         end
         if (k == 3'h2) lp = n;
      end
   end
endmodule // sbm_mem_model
`default_nettype wire

// ### tb/sbm_bank_management_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module sbm_bank_management_tb_top;
   localparam int REFI = 1000;
   logic              clk_i;
   logic              rst_i;
   logic              req_valid_i;
   sbm_pkg::sbm_req_t req_i;
   logic              req_ready_o;
   logic              refresh_busy_o;
   sbm_pkg::sbm_cmd_t mem_cmd_o;
   logic [7:0]        viol;
   int                cyc;
   int                miscompares;
   int                n_checks;
   sbm_pkg::sbm_cmd_t log_a [int];

   sbm_bank_ctrl #(.REFI_CYCLES(REFI)) sbm_bank_ctrl_i
   (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .req_valid_i    (req_valid_i),
      .req_i          (req_i),
      .req_ready_o    (req_ready_o),
      .refresh_busy_o (refresh_busy_o),
      .mem_cmd_o      (mem_cmd_o)
   );

   sbm_mem_model sbm_mem_model_i
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .cmd_i  (mem_cmd_o),
      .viol_o (viol)
   );

   initial clk_i = 1'b0;
   always #50 clk_i = ~clk_i;
   initial cyc = 0;
   always @(posedge clk_i) cyc <= cyc + 1;
   // log by cycle so latency is judged exactly
   always @(negedge clk_i) if (mem_cmd_o.valid === 1'b1) log_a[cyc] = mem_cmd_o;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   function automatic sbm_pkg::sbm_cmd_t mk(input sbm_pkg::sbm_cmd_e_t c, input logic a, input logic [1:0] b,
                                            input logic [12:0] r, input logic [9:0] l);
      return '{valid: 1'b1, cmd: c, all_banks: a, bank: b, row: r, col: l};
   endfunction

   function automatic int find(input sbm_pkg::sbm_cmd_e_t c, input int lo, input int hi);
      for (int i = lo; i <= hi; i++) if (log_a.exists(i) && log_a[i].cmd == c) return i;
      return -1;
   endfunction

   // don't-care fields differ per command kind
   task automatic expect_cmd(input int c, input sbm_pkg::sbm_cmd_t e, input string m);
      logic [29:0] g, mask;
      g = log_a.exists(c) ? log_a[c] : 30'h0;
      case (e.cmd)
         sbm_pkg::SBM_RD, sbm_pkg::SBM_WR: mask = 30'h3fffffff;
         sbm_pkg::SBM_ACT: mask = 30'h3dfffc00;
         sbm_pkg::SBM_PRE: mask = e.all_banks ? 30'h3e000000 : 30'h3f800000;
         default: mask = 30'h3c000000;
      endcase
      chk(32'(g & mask), 32'(e & mask), m);
   endtask

   task automatic issue(input logic w, input logic [1:0] b, input logic [12:0] r, input logic [9:0] c,
                        output int k);
      @(negedge clk_i);
      req_valid_i = 1'b1;
      req_i = '{write: w, bank: b, row: r, col: c};
      k = -1;
      for (int i = 0; i < 400 && k < 0; i++)
      begin
         #1;
         if (req_ready_o === 1'b1) k = cyc;
         else @(negedge clk_i);
      end
      chk(32'(k >= 0), 32'h1, "request never taken");
   endtask

   task automatic idle_wait(input int n);
      @(negedge clk_i);
      req_valid_i = 1'b0;
      repeat (n) @(negedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_closed();
      int k0, k, a;
      k0 = cyc;
      issue(1'b0, 2'h1, 13'h10, 10'h3, k);
      chk(32'(k > k0 + 1), 32'h1, "closed bank accepted at once");
      idle_wait(10);
      a = find(sbm_pkg::SBM_ACT, k0, k + 9);
      expect_cmd(a, mk(sbm_pkg::SBM_ACT, 1'b0, 2'h1, 13'h10, 10'h0), "activate");
      chk(32'(a <= k + 9 - sbm_pkg::TRCD_LC), 32'h1, "activate to read gap");
      expect_cmd(k + 9, mk(sbm_pkg::SBM_RD, 1'b0, 2'h1, 13'h10, 10'h3), "read");
      $display("test closed bank done");
   endtask

   task automatic t_b2b();
      int k [4];
      for (int i = 0; i < 4; i++) issue(i[0], 2'h1, 13'h10, 10'(i * 4), k[i]);
      idle_wait(10);
      for (int i = 0; i < 4; i++)
      begin
         chk(32'(k[i] - k[0]), 32'(i), "hit not taken back to back");
         expect_cmd(k[i] + 9, mk(i[0] ? sbm_pkg::SBM_WR : sbm_pkg::SBM_RD, 1'b0, 2'h1, 13'h10, 10'(i * 4)),
                    "burst command");
      end
      $display("test back to back done");
   endtask

   task automatic t_miss();
      int k0, k, p, a;
      k0 = cyc;
      issue(1'b1, 2'h1, 13'h20, 10'h7, k);
      idle_wait(10);
      p = find(sbm_pkg::SBM_PRE, k0, k + 9);
      a = find(sbm_pkg::SBM_ACT, p, k + 9);
      expect_cmd(p, mk(sbm_pkg::SBM_PRE, 1'b0, 2'h1, 13'h0, 10'h0), "bank precharge");
      expect_cmd(a, mk(sbm_pkg::SBM_ACT, 1'b0, 2'h1, 13'h20, 10'h0), "new row");
      chk(32'(a - p >= sbm_pkg::TRP_LC), 32'h1, "precharge wait");
      expect_cmd(k + 9, mk(sbm_pkg::SBM_WR, 1'b0, 2'h1, 13'h20, 10'h7), "write");
      $display("test row miss done");
   endtask

   task automatic t_refresh();
      int k, rb, p, r, a;
      issue(1'b0, 2'h2, 13'h5, 10'h1, k);
      idle_wait(10);
      rb = -1;
      for (int i = 0; i < REFI + 100 && rb < 0; i++)
      begin
         @(negedge clk_i);
         if (refresh_busy_o === 1'b1) rb = cyc;
      end
      chk(32'(rb >= REFI && rb <= REFI + 2), 32'h1, "refresh interval");
      issue(1'b0, 2'h2, 13'h5, 10'h2, k);
      idle_wait(10);
      p = find(sbm_pkg::SBM_PRE, rb, k + 9);
      r = find(sbm_pkg::SBM_REF, p, k + 9);
      a = find(sbm_pkg::SBM_ACT, r, k + 9);
      expect_cmd(p, mk(sbm_pkg::SBM_PRE, 1'b1, 2'h0, 13'h0, 10'h0), "all bank precharge");
      expect_cmd(r, mk(sbm_pkg::SBM_REF, 1'b0, 2'h0, 13'h0, 10'h0), "refresh");
      chk(32'(r - p >= sbm_pkg::TRP_LC), 32'h1, "refresh precharge wait");
      expect_cmd(a, mk(sbm_pkg::SBM_ACT, 1'b0, 2'h2, 13'h5, 10'h0), "reopen");
      chk(32'(a - r >= sbm_pkg::TRFC_LC), 32'h1, "refresh recovery");
      expect_cmd(k + 9, mk(sbm_pkg::SBM_RD, 1'b0, 2'h2, 13'h5, 10'h2), "read after refresh");
      chk(32'(refresh_busy_o), 32'h0, "refresh pending not cleared");
      $display("test refresh done");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #(3000 * 100);
      miscompares++;
      tally_and_finish();
   end

   initial
   begin
      rst_i       = 1'b1;
      req_valid_i = 1'b0;
      req_i       = '0;
      miscompares = 0;
      n_checks    = 0;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      #1;
      chk(32'({req_ready_o, refresh_busy_o, mem_cmd_o}), 32'h0, "reset outputs");
      t_closed();
      t_b2b();
      t_miss();
      t_refresh();
      chk(32'(viol), 32'h0, "device saw illegal command");
      tally_and_finish();
   end
endmodule // sbm_bank_management_tb_top
`default_nettype wire
